// [core/dsw_core.sv]
`timescale 1ns/10ps
module dsw_core import dsw_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Cyclic command frame, byte 0 in bits 7:0
  input wire logic frm_valid,
  input wire logic [RX_W-1:0] frm_data,
  // Service writes to the mapping objects
  input dsw_sdo_s sdo,
  output logic sdo_ack,
  output logic sdo_err,
  // Drive side conditions and mode
  input dsw_drv_s drv,
  input wire logic [7:0] op_mode,
  input wire logic [15:0] warn_cause,
  input wire logic [31:0] pos_act,
  input wire logic [31:0] pos_int,
  // Cyclic actual frame, byte 0 in bits 7:0
  output logic tx_valid,
  output logic [TX_W-1:0] tx_data,
  // Status and warning object
  output logic [15:0] status_word,
  output logic [15:0] warn_obj,
  // Stored setpoints and power stage commands
  output dsw_setp_s setp,
  output logic power_en,
  output logic setp_accept,
  output logic halt,
  output logic qstop_ramp,
  output logic fault_ramp,
  // Mode dependent control
  output logic new_setpoint,
  output logic apply_now,
  output logic abs_rel,
  output logic home_start
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  // All that the block remembers outside the mapping choice in u_map, as one record.
  typedef struct packed {
    dsw_state_e st;
    logic [15:0] cw;
    dsw_setp_s setp;
    logic [15:0] status;
    logic [15:0] warn;
    logic [TX_W-1:0] tx;
    logic tx_v;
    logic new_sp;
    logic apply;
    logic absrel;
    logic home;
  } dsw_core_s;

  dsw_core_s s_q, s_d;

  // ----------------------------------------------------------------
  // Sub blocks
  // ----------------------------------------------------------------
  logic [15:0] rx_map, tx_map;
  logic rx_ok, tx_ok;
  // Word and setpoints as the current frame would leave them.
  logic [15:0] cw_in;
  dsw_setp_s sp_in;
  dsw_cmd_s cmd;

  // Mapping choice answers the service writes itself.
  dsw_map_sel u_map (
    .mclk(mclk),
    .nrst(nrst),
    .sdo(sdo),
    .rx_map(rx_map),
    .tx_map(tx_map),
    .rx_ok(rx_ok),
    .tx_ok(tx_ok),
    .sdo_ack(sdo_ack),
    .sdo_err(sdo_err)
  );

  // The decode is purely combinational.
  dsw_cmd_decode u_dec (
    .cw(cw_in),
    .cmd(cmd)
  );

  // ----------------------------------------------------------------
  // Frame unpacking
  // ----------------------------------------------------------------
  // Offsets are bytes from bit 0; fields are little endian.
  function automatic logic [15:0] w16(input logic [RX_W-1:0] f,
                                      input int b);
    return f[8*b +: 16];
  endfunction

  // Positions and velocities are four bytes wide.
  function automatic logic [31:0] w32(input logic [RX_W-1:0] f,
                                      input int b);
    return f[8*b +: 32];
  endfunction

  // Fields absent from a mapping keep their stored value.
  always_comb begin
    cw_in = s_q.cw;
    sp_in = s_q.setp;
    case (rx_map)
      // Single setpoint layouts put the word last.
      MAP_RX_POS: begin
        sp_in.pos = w32(frm_data, 0); // RL18
        cw_in = w16(frm_data, 4); // RL18
      end
      MAP_RX_VEL: begin
        sp_in.vel = w32(frm_data, 0); // RL18
        cw_in = w16(frm_data, 4); // RL18
      end
      // Torque is short, so the word sits at byte 2.
      MAP_RX_TRQ: begin
        sp_in.trq = w16(frm_data, 0); // RL18
        cw_in = w16(frm_data, 2); // RL18
      end
      // Both long layouts share the first twelve bytes.
      MAP_RX_IP, MAP_RX_IPR: begin
        cw_in = w16(frm_data, 0); // RL19
        sp_in.pos = w32(frm_data, 2); // RL19
        sp_in.latch = w16(frm_data, 6); // RL19
        sp_in.ff = w16(frm_data, 8); // RL19
        sp_in.dout = w16(frm_data, 10); // RL19
        if (rx_map == MAP_RX_IPR) begin
          sp_in.chg_rst = w16(frm_data, 12); // RL21
        end
      end
      // Short interpolated layout, feed-forward last.
      MAP_RX_IPS: begin
        sp_in.pos = w32(frm_data, 0); // RL20
        cw_in = w16(frm_data, 4); // RL20
        sp_in.ff = w16(frm_data, 6); // RL20
      end
      // Unknown codes cannot be stored; keep the word.
      default: begin
        cw_in = s_q.cw;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State machine, status word and actual frame
  // ----------------------------------------------------------------
  // Frame strobe and control bit edges.
  logic take;
  logic en_rise;
  logic rst_rise;
  logic b4_rise;

  always_comb begin
    s_d = s_q;
    s_d.tx_v = 1'b0;
    s_d.new_sp = 1'b0;
    s_d.home = 1'b0;
    // A frame is only evaluated while a command mapping is active.
    take = frm_valid & rx_ok; // RL25
    // Edges compare with the word of the last taken frame.
    en_rise = cmd.en_op & ~s_q.cw[CW_ENABLE_OP]; // RL23
    rst_rise = cmd.fault_rst & ~s_q.cw[CW_FAULT_RST];
    b4_rise = cw_in[CW_MODE_B4] & ~s_q.cw[CW_MODE_B4];

    // Events from the drive act at once; commands wait for a frame.
    if (drv.fault && s_q.st != ST_FAULT &&
        s_q.st != ST_FAULT_REACT) begin
      s_d.st = ST_FAULT_REACT;
    end else begin
      case (s_q.st)
        // Leave the boot phase once the drive is ready.
        ST_NOT_READY: begin
          if (drv.boot_done) begin
            s_d.st = ST_SWON_DIS;
          end
        end

        // Without DC-link voltage a shutdown is ignored.
        ST_SWON_DIS: begin
          if (take && cmd.shutdown && drv.dc_link) begin
            s_d.st = ST_READY; // RL2
          end
        end

        // Fall back on voltage off, move up on switch on.
        ST_READY: begin
          if (take && (cmd.dis_volt || cmd.qstop)) begin
            s_d.st = ST_SWON_DIS; // RL3
          end else if (take && cmd.switch_on) begin
            s_d.st = ST_SWITCHED_ON; // RL2
          end
        end

        // Enable needs a fresh edge on bit 3, not a level.
        ST_SWITCHED_ON: begin
          if (take && (cmd.dis_volt || cmd.qstop)) begin
            s_d.st = ST_SWON_DIS; // RL3
          end else if (take && cmd.shutdown) begin
            s_d.st = ST_READY; // RL2
          end else if (take && en_rise) begin
            s_d.st = ST_OP_EN; // RL23
          end
        end

        // Commands are tried in order of precedence.
        ST_OP_EN: begin
          if (take && cmd.dis_volt) begin
            s_d.st = ST_SWON_DIS; // RL2
          end else if (take && cmd.qstop) begin
            s_d.st = ST_QSTOP; // RL3
          end else if (take && cmd.shutdown) begin
            s_d.st = ST_READY; // RL2
          end else if (take && cmd.dis_op) begin
            s_d.st = ST_SWITCHED_ON; // RL3
          end
        end

        // The axis follows the quick stop ramp here.
        ST_QSTOP: begin
          // The ramp ends by itself or by a disable voltage command.
          if ((take && cmd.dis_volt) || drv.qstop_done) begin
            s_d.st = ST_SWON_DIS; // RL2
          end else if (take && cmd.en_op) begin
            s_d.st = ST_OP_EN; // RL3
          end
        end

        // The drive reports the end of the emergency ramp.
        ST_FAULT_REACT: begin
          if (drv.fault_done) begin
            s_d.st = ST_FAULT;
          end
        end

        ST_FAULT: begin
          // An edge on reset is needed so a held bit cannot loop.
          if (take && rst_rise && !drv.fault) begin
            s_d.st = ST_SWON_DIS; // RL3
          end
        end

        // Unused codes fall back to not ready.
        default: begin
          s_d.st = ST_NOT_READY;
        end
      endcase
    end

    // Every taken frame stores its word for the edge tests.
    if (take) begin
      s_d.cw = cw_in; // RL1
      s_d.tx_v = 1'b1;
      // Setpoints flow only when enabled and freeze while halted.
      if (s_q.st == ST_OP_EN && !cw_in[CW_HALT]) begin // RL5
        s_d.setp = sp_in; // RL23
      end
      // Mode bits only matter in operation enabled, halted or not.
      if (s_q.st == ST_OP_EN) begin
        case (op_mode)
          MODE_PROFILE_POS_OP: begin
            s_d.new_sp = b4_rise; // RL4
            s_d.apply = cw_in[CW_MODE_B5]; // RL4
            s_d.absrel = cw_in[CW_MODE_B6]; // RL4
          end
          MODE_REFERENCE_SEARCH_OP: begin
            s_d.home = b4_rise; // RL4
            s_d.apply = 1'b0;
            s_d.absrel = 1'b0;
          end
          default: begin
            s_d.apply = 1'b0; // RL4
            s_d.absrel = 1'b0;
          end
        endcase
      end
    end

    // Status bits 6,5,3,2,1,0 from the next state.
    s_d.status = STATUS_RST; // RL12
    // Bit 5 is set only where the state fixes it at one.
    case (s_d.st)
      ST_SWON_DIS: s_d.status[6] = 1'b1; // RL8
      ST_READY: s_d.status[5:0] = 6'h21; // RL8
      ST_SWITCHED_ON: s_d.status[5:0] = 6'h23; // RL8
      ST_OP_EN: s_d.status[5:0] = 6'h27; // RL8
      ST_QSTOP: s_d.status[5:0] = 6'h07; // RL8
      ST_FAULT_REACT: s_d.status[5:0] = 6'h0F; // RL9
      ST_FAULT: s_d.status[5:0] = 6'h08; // RL9
      default: s_d.status[5:0] = 6'h00; // RL8
    endcase
    // Flag bits mirror the drive side levels.
    s_d.status[4] = drv.dc_link; // RL10 RL7
    s_d.status[7] = drv.warn; // RL11
    s_d.status[10] = drv.target; // RL13
    s_d.status[11] = drv.limit; // RL14
    s_d.warn = drv.warn ? warn_cause : 16'h0000; // RL11

    // One actual frame per taken command frame while an actual mapping is active.
    if (take && tx_ok) begin
      // The frame carries the status the port shows next.
      if (tx_map == MAP_TX_INT) begin
        s_d.tx = {s_d.status, pos_int}; // RL22
      end else begin
        s_d.tx = {s_d.status, pos_act}; // RL22
      end
    end else begin
      s_d.tx_v = 1'b0;
    end
  end

  // State register.
  // Reset leaves not ready with only the remote bit set.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.st <= ST_NOT_READY;
      s_q.status <= STATUS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Data outputs come straight from the record.
  assign tx_valid = s_q.tx_v;
  assign tx_data = s_q.tx;
  assign status_word = s_q.status;
  assign warn_obj = s_q.warn;
  assign setp = s_q.setp;
  // Power stage commands decode the current state; halt also needs the stored word.
  assign power_en = s_q.st inside {ST_SWITCHED_ON, ST_OP_EN,
                                   ST_QSTOP, ST_FAULT_REACT};
  assign setp_accept = s_q.st == ST_OP_EN; // RL23
  assign halt = s_q.cw[CW_HALT] & setp_accept; // RL5
  assign qstop_ramp = s_q.st == ST_QSTOP; // RL24
  assign fault_ramp = s_q.st == ST_FAULT_REACT;
  // Mode dependent strobes and levels.
  assign new_setpoint = s_q.new_sp;
  assign apply_now = s_q.apply;
  assign abs_rel = s_q.absrel;
  assign home_start = s_q.home;

endmodule

// [core/dsw_pkg.sv]
// What this block does
// (RL1) Bits: 0 on, 1 voltage, 2 stop low, 3 enable, 7 reset, 8 halt.
// (RL2) 110 is shutdown, 111 switch on, bit 1 low is disable voltage.
// (RL3) Bit 2 low, bit 1 high: quick stop; bit 3 picks enable; bit 7 resets.
// (RL4) Bits 4 to 6 depend on mode: position 01h, homing 06h, others reserved.
// (RL5) Bit 8 halts motion and freezes every stored setpoint.
// (RL6) Control bits 9, 10, 13, 14, 15 carry no function.
// (RL7) Status bits 0-7 show states and flags; 9 remote, 10 target, 11 limit.
// (RL8) State codes on status bits 6,3,2,1,0 with bit 5 per state.
// (RL9) Fault shows bit 3 alone; fault reaction shows bits 3,2,1,0.
// (RL10) Status bit 4 follows DC-link voltage presence.
// (RL11) Status bit 7 flags any warning; cause readable separately.
// (RL12) Status bit 9 always reads one.
// (RL13) Status bit 10 shows the axis reached its target.
// (RL14) Status bit 11 shows motion was or is limited internally.
// (RL15) Command mapping only 1701,1702,1703,1720,1721,1723 via 1C12 sub 1.
// (RL16) Actual mapping accepts only 1B01,1B02,1B20,1B21 via 1C13 sub 1.
// (RL17) Master clears count, writes code, then sets count to one.
// (RL18) 1701 pos+cw, 1702 vel+cw, 1703 torque+cw layouts.
// (RL19) 1720: cw, ip position, latch control, torque ff, digital outputs.
// (RL20) 1721: ip position, cw, torque feed-forward.
// (RL21) 1723: same as 1720 plus changed-input reset word.
// (RL22) 1B01, 1B02 and 1B21 return position then status word.
// (RL23) Switched on stays idle until bit 3 rises, then setpoints flow.
// (RL24) Quick stop active state runs the quick stop ramp.
// (RL25) Evaluate once per frame; only permitted transitions change state.
package dsw_pkg;

  // ----------------------------------------------------------------
  // Control and status word bit positions
  // ----------------------------------------------------------------
  localparam int CW_SWITCH_ON = 0;
  localparam int CW_VOLTAGE = 1;
  localparam int CW_QSTOP_N = 2;
  localparam int CW_ENABLE_OP = 3;
  localparam int CW_MODE_B4 = 4;
  localparam int CW_MODE_B5 = 5;
  localparam int CW_MODE_B6 = 6;
  localparam int CW_FAULT_RST = 7;
  localparam int CW_HALT = 8;
  localparam logic [15:0] STATUS_RST = 16'h0200;

  // ----------------------------------------------------------------
  // Operation modes, mapping objects and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_PROFILE_POS_OP = 8'h01;
  localparam logic [7:0] MODE_REFERENCE_SEARCH_OP = 8'h06;
  localparam logic [15:0] OBJ_RX_ASSIGN = 16'h1C12;
  localparam logic [15:0] OBJ_TX_ASSIGN = 16'h1C13;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_ENTRY = 8'h01;
  localparam logic [15:0] MAP_RX_POS = 16'h1701;
  localparam logic [15:0] MAP_RX_VEL = 16'h1702;
  localparam logic [15:0] MAP_RX_TRQ = 16'h1703;
  localparam logic [15:0] MAP_RX_IP = 16'h1720;
  localparam logic [15:0] MAP_RX_IPS = 16'h1721;
  localparam logic [15:0] MAP_RX_IPR = 16'h1723;
  localparam logic [15:0] MAP_TX_POS = 16'h1B01;
  localparam logic [15:0] MAP_TX_VEL = 16'h1B02;
  localparam logic [15:0] MAP_TX_P20 = 16'h1B20;
  localparam logic [15:0] MAP_TX_INT = 16'h1B21;
  localparam logic [15:0] MAP_RX_RST = 16'h1701;
  localparam logic [15:0] MAP_TX_RST = 16'h1B01;
  localparam logic [7:0] COUNT_RST = 8'h01;
  localparam int RX_W = 112;
  localparam int TX_W = 48;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_NOT_READY, ST_SWON_DIS, ST_READY, ST_SWITCHED_ON,
    ST_OP_EN, ST_QSTOP, ST_FAULT_REACT, ST_FAULT
  } dsw_state_e;

  typedef struct packed {
    logic shutdown;
    logic switch_on;
    logic dis_volt;
    logic qstop;
    logic dis_op;
    logic en_op;
    logic fault_rst;
  } dsw_cmd_s;

  typedef struct packed {
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] data;
  } dsw_sdo_s;

  typedef struct packed {
    logic [31:0] pos;
    logic [31:0] vel;
    logic [15:0] trq;
    logic [15:0] ff;
    logic [15:0] latch;
    logic [15:0] dout;
    logic [15:0] chg_rst;
  } dsw_setp_s;

  typedef struct packed {
    logic boot_done;
    logic dc_link;
    logic fault;
    logic fault_done;
    logic qstop_done;
    logic warn;
    logic target;
    logic limit;
  } dsw_drv_s;

endpackage

// [core/dsw_cmd_decode.sv]
`timescale 1ns/10ps
module dsw_cmd_decode import dsw_pkg::*; (
  // Control word in
  input wire logic [15:0] cw,
  // Decoded device commands
  output dsw_cmd_s cmd
);

  // Bits 9, 10 and 13 to 15 are never looked at here.
  always_comb begin
    cmd = '0; // RL6
    cmd.dis_volt = ~cw[CW_VOLTAGE]; // RL2
    cmd.qstop = cw[CW_VOLTAGE] & ~cw[CW_QSTOP_N]; // RL3
    cmd.shutdown = cw[CW_VOLTAGE] & cw[CW_QSTOP_N] &
                   ~cw[CW_SWITCH_ON]; // RL2
    cmd.switch_on = cw[CW_VOLTAGE] & cw[CW_QSTOP_N] &
                    cw[CW_SWITCH_ON]; // RL2
    cmd.dis_op = cmd.switch_on & ~cw[CW_ENABLE_OP]; // RL3
    cmd.en_op = cmd.switch_on & cw[CW_ENABLE_OP]; // RL3
    cmd.fault_rst = cw[CW_FAULT_RST]; // RL3
  end

endmodule

// [core/dsw_map_sel.sv]
`timescale 1ns/10ps
module dsw_map_sel import dsw_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Service write
  input dsw_sdo_s sdo,
  // Selected mappings
  output logic [15:0] rx_map,
  output logic [15:0] tx_map,
  output logic rx_ok,
  output logic tx_ok,
  // Service answer
  output logic sdo_ack,
  output logic sdo_err
);

  typedef struct packed {
    logic [15:0] rx_map;
    logic [15:0] tx_map;
    logic [7:0] rx_cnt;
    logic [7:0] tx_cnt;
    logic ack;
    logic err;
  } dsw_map_s;

  dsw_map_s s_q, s_d;
  logic rx_obj, tx_obj, rx_code, tx_code;

  // Codes outside the two sets are refused with an error pulse.
  always_comb begin
    rx_obj = sdo.index == OBJ_RX_ASSIGN;
    tx_obj = sdo.index == OBJ_TX_ASSIGN;
    rx_code = sdo.data inside {MAP_RX_POS, MAP_RX_VEL, MAP_RX_TRQ,
                               MAP_RX_IP, MAP_RX_IPS, MAP_RX_IPR}; // RL15
    tx_code = sdo.data inside {MAP_TX_POS, MAP_TX_VEL, MAP_TX_P20,
                               MAP_TX_INT}; // RL16
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    if (sdo.wr) begin
      s_d.err = 1'b1;
      // Count holds zero or one; entry only changes while count is zero.
      if ((rx_obj | tx_obj) && sdo.sub == SUB_COUNT &&
          sdo.data[15:1] == 15'h0000) begin // RL17
        s_d.err = 1'b0;
        if (rx_obj) begin
          s_d.rx_cnt = {7'h00, sdo.data[0]};
        end else begin
          s_d.tx_cnt = {7'h00, sdo.data[0]};
        end
      end else if (rx_obj && sdo.sub == SUB_ENTRY && rx_code &&
                   s_q.rx_cnt == 8'h00) begin // RL15
        s_d.err = 1'b0;
        s_d.rx_map = sdo.data;
      end else if (tx_obj && sdo.sub == SUB_ENTRY && tx_code &&
                   s_q.tx_cnt == 8'h00) begin // RL16
        s_d.err = 1'b0;
        s_d.tx_map = sdo.data;
      end
      s_d.ack = ~s_d.err;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '{MAP_RX_RST, MAP_TX_RST, COUNT_RST, COUNT_RST, 1'b0, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_map = s_q.rx_map;
  assign tx_map = s_q.tx_map;
  assign rx_ok = s_q.rx_cnt == COUNT_RST;
  assign tx_ok = s_q.tx_cnt == COUNT_RST;
  assign sdo_ack = s_q.ack;
  assign sdo_err = s_q.err;

endmodule

// [dv/dsw_checker.sv]
`timescale 1ns/10ps
module dsw_checker import dsw_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Watched ports
  input wire logic frm_valid,
  input dsw_sdo_s sdo,
  input wire logic sdo_ack,
  input wire logic sdo_err,
  input dsw_drv_s drv,
  input wire logic [15:0] warn_cause,
  input wire logic tx_valid,
  input wire logic [TX_W-1:0] tx_data,
  input wire logic [15:0] status_word,
  input wire logic [15:0] warn_obj,
  input dsw_setp_s setp,
  input wire logic setp_accept,
  input wire logic halt,
  input wire logic qstop_ramp,
  input wire logic fault_ramp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // ----
  // Service write handshake
  // ----
  sequence s_sdo_req;
    sdo.wr;
  endsequence
  sequence s_sdo_answer;
    sdo_ack ^ sdo_err;
  endsequence
  // Each write gets exactly one verdict, and none comes unasked.
  a_sdo_one_answer: assert property (s_sdo_req |=> s_sdo_answer)
    else $error("service write not answered once");
  a_sdo_no_spurious: assert property (
    (sdo_ack || sdo_err) |-> $past(sdo.wr))
    else $error("service answer without a write");

  // ----
  // Frames, status and setpoints
  // ----
  a_tx_after_frame: assert property (tx_valid |-> $past(frm_valid))
    else $error("actual frame without command frame");
  a_tx_status_pair: assert property (
    tx_valid |-> tx_data[47:32] == status_word)
    else $error("actual frame status differs");
  a_remote_always: assert property (status_word[9])
    else $error("remote bit low");
  a_accept_code: assert property (
    setp_accept |-> (status_word & 16'h006F) == 16'h0027)
    else $error("setpoint flow outside enabled state");
  a_qstop_code: assert property (
    qstop_ramp |-> (status_word & 16'h006F) == 16'h0007)
    else $error("quick stop ramp with wrong status");
  a_fault_entry: assert property (
    $rose(fault_ramp) |-> $past(drv.fault))
    else $error("fault reaction without fault");
  a_halt_freeze: assert property (
    halt |-> $stable(setp))
    else $error("setpoints moved while halted");
  a_warn_mirror: assert property (1'b1 |=> warn_obj ==
    ($past(drv.warn) ? $past(warn_cause) : 16'h0000))
    else $error("warning object wrong");
endmodule

bind dsw_core dsw_checker u_chk (.mclk, .nrst, .frm_valid, .sdo, .sdo_ack,
  .sdo_err, .drv, .warn_cause, .tx_valid, .tx_data, .status_word,
  .warn_obj, .setp, .setp_accept, .halt, .qstop_ramp, .fault_ramp);

// [dv/dsw_master.sv]
`timescale 1ns/10ps
module dsw_master import dsw_pkg::*; (
  // Clock
  input wire logic mclk,
  // Command frames and service writes
  output logic frm_valid,
  output logic [RX_W-1:0] frm_data,
  output dsw_sdo_s sdo,
  // Answers
  input wire logic sdo_ack,
  input wire logic sdo_err,
  input wire logic tx_valid,
  input wire logic [TX_W-1:0] tx_data
);
  logic [15:0] rx_map = MAP_RX_RST;
  logic [TX_W-1:0] last_tx = '0;
  logic got_tx = 1'b0;

  initial begin
    frm_valid = 1'b0;
    frm_data = '0;
    sdo = '0;
  end

  // Lay the fields out per the chosen mapping; released lines are inverted
  // so that a late read of stale bytes cannot pass by luck.
  task automatic send(input logic [15:0] cw, input logic [31:0] v,
                      input logic [15:0] w);
    logic [RX_W-1:0] f;
    f = '0;
    case (rx_map)
      MAP_RX_TRQ: f[31:0] = {cw, w};
      MAP_RX_IPS: f[63:0] = {w + 16'h0001, cw, v};
      MAP_RX_IP: f[95:0] = {w + 16'h0002, w + 16'h0001, w, v, cw};
      MAP_RX_IPR: f = {w + 16'h0003, w + 16'h0002, w + 16'h0001, w, v,
                       cw};
      default: f[47:0] = {cw, v};
    endcase
    @(posedge mclk);
    frm_valid <= 1'b1;
    frm_data <= f;
    @(posedge mclk);
    frm_valid <= 1'b0;
    frm_data <= ~f;
    @(posedge mclk);
    got_tx = tx_valid;
    last_tx = tx_data;
  endtask

  // One service write; the answer is taken one cycle after the write.
  task automatic wr(input logic [15:0] idx, input logic [7:0] sb,
                    input logic [15:0] d, output logic ok);
    @(posedge mclk);
    sdo <= '{1'b1, idx, sb, d};
    @(posedge mclk);
    sdo <= '{1'b0, idx, sb, ~d};
    @(posedge mclk);
    ok = sdo_ack & ~sdo_err;
  endtask

  // Mapping choice in the three ordered steps.
  task automatic sel(input logic [15:0] obj, input logic [15:0] code,
                     output logic ok);
    logic a;
    logic b;
    logic c;
    wr(obj, SUB_COUNT, 16'h0000, a);
    wr(obj, SUB_ENTRY, code, b);
    wr(obj, SUB_COUNT, 16'h0001, c);
    ok = a & b & c;
    if (ok && obj == OBJ_RX_ASSIGN) begin
      rx_map = code;
    end
  endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
module tb_top import dsw_pkg::*;;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  // Drive flags packed as boot,dclink,fault,fdone,qdone,warn,target,limit.
  dsw_drv_s drv = '0;
  logic [7:0] op_mode = 8'h01;
  logic [15:0] warn_cause = 16'h0000;
  logic [31:0] pos_act = 32'h12345678;
  logic [31:0] pos_int = 32'h9ABCDEF0;
  logic frm_valid;
  logic [RX_W-1:0] frm_data;
  dsw_sdo_s sdo;
  logic sdo_ack, sdo_err, tx_valid, power_en, setp_accept, halt;
  logic qstop_ramp, fault_ramp, new_setpoint, apply_now, abs_rel;
  logic home_start;
  logic [TX_W-1:0] tx_data;
  logic [15:0] status_word, warn_obj;
  dsw_setp_s setp;
  int err_count = 0;
  int cmp_count = 0;
  logic ok;
  logic [31:0] v;
  logic [15:0] w;
  logic [15:0] rx_codes [6] = '{MAP_RX_VEL, MAP_RX_TRQ, MAP_RX_IP,
    MAP_RX_IPS, MAP_RX_IPR, MAP_RX_POS};
  logic [15:0] tx_codes [3] = '{MAP_TX_VEL, MAP_TX_P20, MAP_TX_INT};

  always #10 mclk = ~mclk;

  dsw_core DUT (.mclk, .nrst, .frm_valid, .frm_data, .sdo, .sdo_ack,
    .sdo_err, .drv, .op_mode, .warn_cause, .pos_act, .pos_int, .tx_valid,
    .tx_data, .status_word, .warn_obj, .setp, .power_en, .setp_accept,
    .halt, .qstop_ramp, .fault_ramp, .new_setpoint, .apply_now, .abs_rel,
    .home_start);

  dsw_master u_mst (.mclk, .frm_valid, .frm_data, .sdo, .sdo_ack,
    .sdo_err, .tx_valid, .tx_data);

  // ----
  // Shared checks
  // ----
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fs(input logic [15:0] cw, input logic [15:0] exp);
    u_mst.send(cw, 32'h00000000, 16'h0000);
    chk(status_word, exp);
  endtask

  task automatic results();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The whole run is about two hundred cycles; this cuts a hang short.
  initial begin
    #200us;
    err_count++;
    results();
  end

  // ----
  // Test sequence
  // ----
  initial begin
    repeat (8) @(posedge mclk);
    chk(status_word, 16'h0200);
    nrst <= 1'b1;
    drv <= 8'hC0;
    fs(16'h0006, 16'h0231);
    chk({u_mst.got_tx, u_mst.last_tx}, {1'b1, 16'h0231, pos_act});
    fs(16'h0007, 16'h0233);
    fs(16'h000F, 16'h0237);
    u_mst.send(16'h000F, 32'hAABBCCDD, 16'h0000);
    chk(setp.pos, 32'hAABBCCDD);
    u_mst.send(16'h010F, 32'h11111111, 16'h0000);
    chk({halt, setp.pos}, {1'b1, 32'hAABBCCDD});
    fs(16'hE67F, 16'h0237);
    chk({new_setpoint, apply_now, abs_rel}, 3'b111);
    op_mode <= 8'h03;
    fs(16'h007F, 16'h0237);
    chk({apply_now, abs_rel}, 2'b00);
    drv <= 8'hC7;
    warn_cause <= 16'h0042;
    fs(16'h000F, 16'h0EB7);
    chk(warn_obj, 16'h0042);
    drv <= 8'hC0;
    op_mode <= 8'h06;
    fs(16'h001F, 16'h0237);
    chk({home_start, new_setpoint, power_en}, 3'b101);
    // Refusals leave count and mapping as they were.
    u_mst.sel(OBJ_RX_ASSIGN, 16'h1704, ok);
    chk(ok, 1'b0);
    u_mst.wr(OBJ_RX_ASSIGN, SUB_ENTRY, MAP_RX_VEL, ok);
    chk(ok, 1'b0);
    u_mst.wr(OBJ_RX_ASSIGN, SUB_COUNT, 16'h0002, ok);
    chk(ok, 1'b0);
    u_mst.wr(OBJ_RX_ASSIGN, SUB_COUNT, 16'h0000, ok);
    u_mst.send(16'h000F, 32'h00000000, 16'h0000);
    chk(u_mst.got_tx, 1'b0);
    u_mst.wr(OBJ_RX_ASSIGN, SUB_COUNT, 16'h0001, ok);
    foreach (rx_codes[i]) begin
      u_mst.sel(OBJ_RX_ASSIGN, rx_codes[i], ok);
      chk(ok, 1'b1);
      v = {16'hC0DE, 16'(i)};
      w = {8'hBE, 8'(i)};
      u_mst.send(16'h000F, v, w);
      chk(status_word, 16'h0237);
      case (rx_codes[i])
        MAP_RX_POS: chk(setp.pos, v);
        MAP_RX_VEL: chk(setp.vel, v);
        MAP_RX_TRQ: chk(setp.trq, w);
        MAP_RX_IPS: chk({setp.pos, setp.ff}, {v, w + 16'h0001});
        default: chk({setp.pos, setp.latch, setp.ff, setp.dout},
          {v, w, w + 16'h0001, w + 16'h0002});
      endcase
      if (rx_codes[i] == MAP_RX_IPR) begin
        chk(setp.chg_rst, w + 16'h0003);
      end
    end
    u_mst.sel(OBJ_TX_ASSIGN, 16'h1B03, ok);
    chk(ok, 1'b0);
    foreach (tx_codes[i]) begin
      u_mst.sel(OBJ_TX_ASSIGN, tx_codes[i], ok);
      chk(ok, 1'b1);
    end
    fs(16'h000F, 16'h0237);
    chk(u_mst.last_tx, {16'h0237, pos_int});
    fs(16'h0000, 16'h0250);
    fs(16'h0006, 16'h0231);
    fs(16'h000F, 16'h0233);
    fs(16'h000F, 16'h0233);
    fs(16'h0007, 16'h0233);
    fs(16'h000F, 16'h0237);
    fs(16'h000B, 16'h0217);
    chk(qstop_ramp, 1'b1);
    drv <= 8'hC8;
    fs(16'h0000, 16'h0250);
    drv <= 8'h80;
    fs(16'h0000, 16'h0240);
    drv <= 8'hE0;
    fs(16'h0000, 16'h021F);
    chk(fault_ramp, 1'b1);
    drv <= 8'hF0;
    fs(16'h0000, 16'h0218);
    drv <= 8'hC0;
    fs(16'h0080, 16'h0250);
    results();
  end
endmodule
